// file: hdl/rpi_regs.vh
// Register map and field positions of the receive-port interrupt block
`ifndef RPI_REGS_VH
`define RPI_REGS_VH
`define RPI_ADDR_ENABLE_HIGH 8'hD8
`define RPI_ADDR_ENABLE_LOW 8'hD9
`define RPI_ADDR_STATUS_HIGH 8'hDA
`define RPI_ADDR_STATUS_LOW 8'hDB
`define RPI_ADDR_GPIO_STATUS 8'hDC
`define RPI_ADDR_GPIO_EDGE 8'hDD
`define RPI_ADDR_SENSOR_RISE 8'hDE
`define RPI_ADDR_SENSOR_FALL 8'hDF
`define RPI_ADDR_CSI_STATUS 8'h7A
`define RPI_RESET_BYTE 8'h00
`define RPI_ZERO_BYTE 8'h00
`define RPI_HIGH_ENABLE_MASK 8'h07
`define RPI_LOW_ENABLE_MASK 8'h7F
`define RPI_HIGH_STATUS_MASK 8'h1F
`define RPI_LOW_STATUS_MASK 8'h7F
`define RPI_GPIO_COUNT 4
`define RPI_GPIO_RESET 4'h0
// High status bits
`define RPI_HI_FWD_GPIO 4
`define RPI_HI_SENSOR 3
`define RPI_HI_ENCODING 2
`define RPI_HI_SEQUENCE 1
`define RPI_HI_CRC 0
// Low status and enable bits
`define RPI_LO_LINE_LENGTH 6
`define RPI_LO_LINE_COUNT 5
`define RPI_LO_BUFFER 4
`define RPI_LO_CSI 3
`define RPI_LO_PARITY 2
`define RPI_LO_PORT_VALID 1
`define RPI_LO_LOCK 0
// Field positions in the forward GPIO status register
`define RPI_GPIO_LATCH_LSB 4
`define RPI_GPIO_LEVEL_LSB 0
`endif

// file: hdl/rpi_port_irq.v
// Receive-port interrupt enables, latched status and forward GPIO edge flags
`timescale 1ns/1ps
`include "rpi_regs.vh"

// Operation
// - Line length change raises port interrupt when enable bit 6 set.
// - Line count change raises port interrupt when enable bit 5 set.
// - Receive buffer overflow raises port interrupt when enable bit 4 set.
// - CSI receiver error raises port interrupt when enable bit 3 set.
// - Link parity error raises port interrupt when enable bit 2 set.
// - Port valid change raises port interrupt when enable bit 1 set.
// - Lock status change raises port interrupt when enable bit 0 set.
// - High status bit 4 set on enabled GPIO edge, cleared reading GPIO status.
// - High status bit 3 set on sensor change, cleared after both reads.
// - High status bit 2 encoding error, cleared reading port status two.
// - High status bit 1 sequence error, cleared reading port status one.
// - High status bit 0 CRC error, cleared reading port status one.
// - Low bits 6..4 line and buffer events, cleared reading status two.
// - Low bit 3 CSI error, cleared when CSI receive status read.
// - Low bits 2..0 parity, valid, lock, cleared reading status one.
// - GPIO status bits 7..4 latch GPIO3..0 events, clear on read.
// - GPIO status bits 3..0 show live forward GPIO3..0 levels.
// - Edge enable odd bits falling, even bits rising, per GPIO.
// - High enable bits 0..2 gate CRC, sequence, encoding interrupts.
module rpi_port_irq (
    // Clock, reset, enable
    input wire clk_in,
    input wire rst_in,
    input wire clk_en_in,
    // Register access, qualified here by port_selected_in and clk_en_in
    input wire port_selected_in,
    input wire reg_write_in,
    input wire reg_read_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    output reg reg_rvalid_out,
    // Event pulses from the receive port
    input wire line_length_change_in,
    input wire line_count_change_in,
    input wire buffer_overflow_in,
    input wire csi_receive_error_in,
    input wire link_parity_error_in,
    input wire port_valid_change_in,
    input wire lock_change_in,
    input wire link_encoding_error_in,
    input wire ctrl_channel_sequence_in,
    input wire ctrl_channel_crc_in,
    input wire sensor_change_in,
    // Live forward channel GPIO levels
    input wire [3:0] fwd_gpio_level_in,
    // Combined port interrupt
    output reg port_irq_out
);

    reg [7:0] port_irq_enable_high;
    reg [7:0] port_irq_enable_low;
    reg [7:0] port_irq_status_high;
    reg [7:0] port_irq_status_low;
    reg [7:0] fwd_gpio_edge_enable;
    reg [3:0] gpio_irq_latched;
    reg [3:0] gpio_level_prev;
    reg sensor_rise_read_seen;
    reg sensor_fall_read_seen;
    reg [7:0] next_rdata;
    reg [3:0] next_gpio_latched;
    reg [7:0] next_status_high;
    reg [7:0] next_status_low;
    reg [7:0] clr_high;
    reg [7:0] clr_low;
    reg [7:0] set_high;
    reg [7:0] set_low;
    reg next_rise_seen;
    reg next_fall_seen;
    reg [3:0] gpio_rise;
    reg [3:0] gpio_fall;
    reg [3:0] gpio_event;
    integer i;

    wire wr = clk_en_in && port_selected_in && reg_write_in;
    wire rd = clk_en_in && port_selected_in && reg_read_in;
    wire rd_sts1 = rd && (reg_addr_in == `RPI_ADDR_STATUS_HIGH);
    wire rd_sts2 = rd && (reg_addr_in == `RPI_ADDR_STATUS_LOW);
    wire rd_gpio = rd && (reg_addr_in == `RPI_ADDR_GPIO_STATUS);
    wire rd_csi = rd && (reg_addr_in == `RPI_ADDR_CSI_STATUS);
    wire rd_rise = rd && (reg_addr_in == `RPI_ADDR_SENSOR_RISE);
    wire rd_fall = rd && (reg_addr_in == `RPI_ADDR_SENSOR_FALL);

    // Edge detection on the live GPIO levels
    always @* begin
        for (i = 0; i < `RPI_GPIO_COUNT; i = i + 1) begin
            gpio_rise[i] = fwd_gpio_level_in[i] & ~gpio_level_prev[i];
            gpio_fall[i] = ~fwd_gpio_level_in[i] & gpio_level_prev[i];
            gpio_event[i] = (gpio_rise[i] & fwd_gpio_edge_enable[2 * i])
                | (gpio_fall[i] & fwd_gpio_edge_enable[2 * i + 1]);
        end
    end

    // Set and clear terms; set wins over a clearing read
    always @* begin
        set_low = `RPI_ZERO_BYTE;
        set_high = `RPI_ZERO_BYTE;
        clr_low = `RPI_ZERO_BYTE;
        clr_high = `RPI_ZERO_BYTE;
        set_low[`RPI_LO_LINE_LENGTH] = line_length_change_in
            & port_irq_enable_low[`RPI_LO_LINE_LENGTH];
        set_low[`RPI_LO_LINE_COUNT] = line_count_change_in
            & port_irq_enable_low[`RPI_LO_LINE_COUNT];
        set_low[`RPI_LO_BUFFER] = buffer_overflow_in
            & port_irq_enable_low[`RPI_LO_BUFFER];
        set_low[`RPI_LO_CSI] = csi_receive_error_in
            & port_irq_enable_low[`RPI_LO_CSI];
        set_low[`RPI_LO_PARITY] = link_parity_error_in
            & port_irq_enable_low[`RPI_LO_PARITY];
        set_low[`RPI_LO_PORT_VALID] = port_valid_change_in
            & port_irq_enable_low[`RPI_LO_PORT_VALID];
        set_low[`RPI_LO_LOCK] = lock_change_in
            & port_irq_enable_low[`RPI_LO_LOCK];
        // Forward GPIO and sensor summaries follow their own latches
        set_high[`RPI_HI_FWD_GPIO] = |gpio_event;
        set_high[`RPI_HI_SENSOR] = sensor_change_in;
        set_high[`RPI_HI_ENCODING] = link_encoding_error_in
            & port_irq_enable_high[`RPI_HI_ENCODING];
        set_high[`RPI_HI_SEQUENCE] = ctrl_channel_sequence_in
            & port_irq_enable_high[`RPI_HI_SEQUENCE];
        set_high[`RPI_HI_CRC] = ctrl_channel_crc_in
            & port_irq_enable_high[`RPI_HI_CRC];
        clr_low[`RPI_LO_LINE_LENGTH] = rd_sts2;
        clr_low[`RPI_LO_LINE_COUNT] = rd_sts2;
        clr_low[`RPI_LO_BUFFER] = rd_sts2;
        clr_low[`RPI_LO_CSI] = rd_csi;
        clr_low[`RPI_LO_PARITY] = rd_sts1;
        clr_low[`RPI_LO_PORT_VALID] = rd_sts1;
        clr_low[`RPI_LO_LOCK] = rd_sts1;
        clr_high[`RPI_HI_FWD_GPIO] = rd_gpio;
        clr_high[`RPI_HI_SENSOR] = next_rise_seen & next_fall_seen;
        clr_high[`RPI_HI_ENCODING] = rd_sts2;
        clr_high[`RPI_HI_SEQUENCE] = rd_sts1;
        clr_high[`RPI_HI_CRC] = rd_sts1;
        next_status_low = ((port_irq_status_low & ~clr_low) | set_low)
            & `RPI_LOW_STATUS_MASK;
        next_status_high = ((port_irq_status_high & ~clr_high) | set_high)
            & `RPI_HIGH_STATUS_MASK;
        next_gpio_latched = (rd_gpio ? `RPI_GPIO_RESET : gpio_irq_latched)
            | gpio_event;
    end

    // Both sensor status reads must be seen since the flag last set
    always @* begin
        next_rise_seen = sensor_rise_read_seen | rd_rise;
        next_fall_seen = sensor_fall_read_seen | rd_fall;
    end

    // Read data mux
    always @* begin
        next_rdata = `RPI_ZERO_BYTE;
        if (reg_addr_in == `RPI_ADDR_ENABLE_HIGH) begin
            next_rdata = port_irq_enable_high;
        end else if (reg_addr_in == `RPI_ADDR_ENABLE_LOW) begin
            next_rdata = port_irq_enable_low;
        end else if (reg_addr_in == `RPI_ADDR_STATUS_HIGH) begin
            next_rdata = port_irq_status_high;
        end else if (reg_addr_in == `RPI_ADDR_STATUS_LOW) begin
            next_rdata = port_irq_status_low;
        end else if (reg_addr_in == `RPI_ADDR_GPIO_STATUS) begin
            next_rdata = {gpio_irq_latched, fwd_gpio_level_in};
        end else if (reg_addr_in == `RPI_ADDR_GPIO_EDGE) begin
            next_rdata = fwd_gpio_edge_enable;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            port_irq_enable_high <= `RPI_RESET_BYTE;
            port_irq_enable_low <= `RPI_RESET_BYTE;
            port_irq_status_high <= `RPI_RESET_BYTE;
            port_irq_status_low <= `RPI_RESET_BYTE;
            fwd_gpio_edge_enable <= `RPI_RESET_BYTE;
            gpio_irq_latched <= `RPI_GPIO_RESET;
            gpio_level_prev <= `RPI_GPIO_RESET;
            sensor_rise_read_seen <= 1'b0;
            sensor_fall_read_seen <= 1'b0;
            reg_rdata_out <= `RPI_RESET_BYTE;
            reg_rvalid_out <= 1'b0;
            port_irq_out <= 1'b0;
        end else if (clk_en_in) begin
            gpio_level_prev <= fwd_gpio_level_in;
            gpio_irq_latched <= next_gpio_latched;
            port_irq_status_low <= next_status_low;
            port_irq_status_high <= next_status_high;
            // Read tracking restarts whenever a new sensor event arrives
            if (sensor_change_in || clr_high[`RPI_HI_SENSOR]) begin
                sensor_rise_read_seen <= 1'b0;
                sensor_fall_read_seen <= 1'b0;
            end else begin
                sensor_rise_read_seen <= next_rise_seen;
                sensor_fall_read_seen <= next_fall_seen;
            end
            if (wr) begin
                if (reg_addr_in == `RPI_ADDR_ENABLE_HIGH) begin
                    port_irq_enable_high <= reg_wdata_in & `RPI_HIGH_ENABLE_MASK;
                end else if (reg_addr_in == `RPI_ADDR_ENABLE_LOW) begin
                    port_irq_enable_low <= reg_wdata_in & `RPI_LOW_ENABLE_MASK;
                end else if (reg_addr_in == `RPI_ADDR_GPIO_EDGE) begin
                    fwd_gpio_edge_enable <= reg_wdata_in;
                end
            end
            reg_rvalid_out <= rd;
            if (rd) begin
                reg_rdata_out <= next_rdata;
            end
            port_irq_out <= (|next_status_low) | (|next_status_high);
        end
    end

endmodule // rpi_port_irq

// file: bench/rpi_port_irq_monitor.sv
// Port checker for the receive-port interrupt block
`timescale 1ns/1ps
module rpi_port_irq_monitor (
    // Clock and control
    input wire clk_in, input wire rst_in, input wire clk_en_in, input wire port_selected_in,
    // Register access
    input wire reg_write_in, input wire reg_read_in, input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in, input wire [7:0] reg_rdata_out, input wire reg_rvalid_out,
    // Events, GPIO levels, interrupt
    input wire line_length_change_in, input wire line_count_change_in,
    input wire buffer_overflow_in, input wire csi_receive_error_in,
    input wire link_parity_error_in, input wire port_valid_change_in,
    input wire lock_change_in, input wire link_encoding_error_in,
    input wire ctrl_channel_sequence_in, input wire ctrl_channel_crc_in,
    input wire sensor_change_in, input wire [3:0] fwd_gpio_level_in, input wire port_irq_out
);
    wire ev_any = line_length_change_in | line_count_change_in | buffer_overflow_in
        | csi_receive_error_in | link_parity_error_in | port_valid_change_in | lock_change_in
        | link_encoding_error_in | ctrl_channel_sequence_in | ctrl_channel_crc_in
        | sensor_change_in;
    wire acc_rd = clk_en_in & port_selected_in & reg_read_in;
    wire q_rd = acc_rd & ~ev_any;
    wire rd_da = q_rd & (reg_addr_in == 8'hDA);
    wire rd_db = q_rd & (reg_addr_in == 8'hDB);
    wire rd_dc = q_rd & (reg_addr_in == 8'hDC);
    wire rd_csi = q_rd & (reg_addr_in == 8'h7A);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_two; rd_db ##1 rd_db |=> reg_rdata_out[6:4] == 3'b000; endproperty
    a_two: assert property (p_two) else $error("low 6..4 kept");
    property p_one; rd_da ##1 rd_db |=> reg_rdata_out[2:0] == 3'b000; endproperty
    a_one: assert property (p_one) else $error("low 2..0 kept");
    property p_csi; rd_csi ##1 rd_db |=> !reg_rdata_out[3]; endproperty
    a_csi: assert property (p_csi) else $error("low 3 kept");
    property p_hi; rd_db ##1 rd_da |=> !reg_rdata_out[2]; endproperty
    a_hi: assert property (p_hi) else $error("high 2 kept");
    property p_hl; rd_da ##1 rd_da |=> reg_rdata_out[1:0] == 2'b00; endproperty
    a_hl: assert property (p_hl) else $error("high 1..0 kept");
    property p_gl; (rd_dc && $stable(fwd_gpio_level_in)) ##1
        (rd_dc && $stable(fwd_gpio_level_in)) |=> reg_rdata_out[7:4] == 4'h0; endproperty
    a_gl: assert property (p_gl) else $error("gpio latch kept");
    property p_fg; (rd_dc && $stable(fwd_gpio_level_in)) ##1
        (rd_da && $stable(fwd_gpio_level_in)) |=> !reg_rdata_out[4]; endproperty
    a_fg: assert property (p_fg) else $error("high 4 kept");
    property p_lv; rd_dc |=> reg_rdata_out[3:0] == $past(fwd_gpio_level_in); endproperty
    a_lv: assert property (p_lv) else $error("gpio level wrong");
    property p_fall; $fell(port_irq_out) |-> $past(acc_rd); endproperty
    a_fall: assert property (p_fall) else $error("irq fell without read");
    property p_sel; reg_read_in && !(clk_en_in && port_selected_in) |=> !reg_rvalid_out;
    endproperty
    a_sel: assert property (p_sel) else $error("unselected read answered");
    c_rise: cover property ($rose(port_irq_out));
    c_fall: cover property ($fell(port_irq_out));
    c_gl: cover property (rd_dc ##1 rd_dc);
endmodule // rpi_port_irq_monitor

bind rpi_port_irq rpi_port_irq_monitor u_mon (.*);

// file: bench/rpi_port_irq_tb_top.sv
// Self-checking bench for the receive-port interrupt block
`timescale 1ns/1ps
module rpi_port_irq_tb_top;
    reg clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg clk_en_in = 1'b1;
    reg port_selected_in = 1'b1;
    reg reg_write_in = 1'b0;
    reg reg_read_in = 1'b0;
    reg [7:0] reg_addr_in = 8'h00;
    reg [7:0] reg_wdata_in = 8'h00;
    reg [3:0] fwd_gpio_level_in = 4'h0;
    reg line_length_change_in, line_count_change_in, buffer_overflow_in, csi_receive_error_in;
    reg link_parity_error_in, port_valid_change_in, lock_change_in, link_encoding_error_in;
    reg ctrl_channel_sequence_in, ctrl_channel_crc_in, sensor_change_in;
    wire [7:0] reg_rdata_out;
    wire reg_rvalid_out;
    wire port_irq_out;
    integer fail_count = 0;
    integer samples_checked = 0;
    integer i;
    reg [7:0] st, b, clr;
    rpi_port_irq u_dut (.*);
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task complete_run;
        if (fail_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task set_ev(input [10:0] m);
        {sensor_change_in, link_encoding_error_in, ctrl_channel_sequence_in, ctrl_channel_crc_in,
            line_length_change_in, line_count_change_in, buffer_overflow_in, csi_receive_error_in,
            link_parity_error_in, port_valid_change_in, lock_change_in} = m;
    endtask
    task idle;
        reg_read_in = 1'b0;
        reg_write_in = 1'b0;
        @(negedge clk_in);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        reg_read_in = 1'b0;
        reg_write_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clk_in);
    endtask
    task rd(input [7:0] a, input [7:0] e);
        reg_write_in = 1'b0;
        reg_read_in = 1'b1;
        reg_addr_in = a;
        @(negedge clk_in);
        chk("rdata", reg_rdata_out, e);
    endtask
    initial forever #25 clk_in = ~clk_in;
    initial begin
        repeat (2000) @(posedge clk_in);
        fail_count = fail_count + 1;
        complete_run;
    end
    initial begin
        set_ev(11'h000);
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        for (i = 0; i < 6; i = i + 1) rd(8'hD8 + i[7:0], 8'h00);
        chk("rvalid", {7'h00, reg_rvalid_out}, 8'h01);
        wr(8'hDA, 8'hFF);
        rd(8'hDA, 8'h00);
        rd(8'hE0, 8'h00);
        set_ev(11'h3FF);
        idle;
        set_ev(11'h000);
        rd(8'hDB, 8'h00);
        port_selected_in = 1'b0;
        wr(8'hD9, 8'hFF);
        rd(8'hD9, 8'h00);
        chk("rvalid", {7'h00, reg_rvalid_out}, 8'h00);
        port_selected_in = 1'b1;
        rd(8'hD9, 8'h00);
        wr(8'hD9, 8'hFF);
        wr(8'hD8, 8'hFF);
        rd(8'hD9, 8'h7F);
        rd(8'hD8, 8'h07);
        clk_en_in = 1'b0;
        set_ev(11'h001);
        idle;
        set_ev(11'h000);
        clk_en_in = 1'b1;
        idle;
        chk("irq", {7'h00, port_irq_out}, 8'h00);
        rd(8'hDB, 8'h00);
        for (i = 0; i < 11; i = i + 1) begin
            st = (i < 7) ? 8'hDB : 8'hDA;
            b = 8'h01 << ((i < 7) ? i : i - 7);
            clr = (i == 3) ? 8'h7A : (i == 10) ? 8'hDF
                : (i == 9 || (i > 3 && i < 7)) ? 8'hDB : 8'hDA;
            set_ev(11'h001 << i);
            idle;
            set_ev(11'h000);
            chk("irq", {7'h00, port_irq_out}, 8'h01);
            rd(st, b);
            if (i == 10) begin
                rd(8'hDE, 8'h00);
                rd(st, b);
            end
            if (clr != st) rd(clr, 8'h00);
            rd(st, 8'h00);
            chk("irq", {7'h00, port_irq_out}, 8'h00);
        end
        fwd_gpio_level_in = 4'hF;
        idle;
        rd(8'hDC, 8'h0F);
        wr(8'hDD, 8'h55);
        fwd_gpio_level_in = 4'h0;
        idle;
        rd(8'hDC, 8'h00);
        fwd_gpio_level_in = 4'hF;
        idle;
        rd(8'hDA, 8'h10);
        rd(8'hDC, 8'hFF);
        rd(8'hDC, 8'h0F);
        rd(8'hDA, 8'h00);
        wr(8'hDD, 8'h80);
        idle;
        fwd_gpio_level_in = 4'h0;
        idle;
        rd(8'hDD, 8'h80);
        rd(8'hDC, 8'h80);
        complete_run;
    end
endmodule // rpi_port_irq_tb_top
